// ===== rtl/pwb_pkg.sv
// package: timing constants, pulse classes and the event carrier struct for the bit-signal layer
package pwb_pkg;
  // clock rate in kHz (10 MHz)
  localparam int unsigned CLK_KHZ = 10000;
  // times in ns as printed, power-up limit in ms
  localparam int unsigned IDLE_HIGH_TIME_NS = 11000;
  localparam int unsigned MASTER_SHORT_MIN_NS = 11800;
  localparam int unsigned MASTER_SHORT_MAX_NS = 17000;
  localparam int unsigned MASTER_LONG_MIN_NS = 35400;
  localparam int unsigned MASTER_LONG_MAX_NS = 48900;
  localparam int unsigned EDGE_DETECT_LATENCY_NS = 9600;
  localparam int unsigned SLAVE_READ_ONE_MIN_NS = 28300;
  localparam int unsigned SLAVE_READ_ONE_MAX_NS = 38300;
  localparam int unsigned MASTER_START_MIN_NS = 80000;
  localparam int unsigned MASTER_START_MAX_NS = 109000;
  localparam int unsigned SLAVE_ATTENTION_MAX_NS = 165000;
  localparam int unsigned RESET_MIN_NS = 354000;
  localparam int unsigned POWERUP_MAX_MS = 500;
  // cycle counts: least times round up, longest times round down
  localparam int unsigned IDLE_HIGH_CYC = (IDLE_HIGH_TIME_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned EDGE_DET_CYC = (EDGE_DETECT_LATENCY_NS * CLK_KHZ) / 1000000;
  // read-one drive: midpoint of the allowed window
  localparam int unsigned READ_ONE_CYC =
    ((SLAVE_READ_ONE_MIN_NS + SLAVE_READ_ONE_MAX_NS) / 2 * CLK_KHZ) / 1000000;
  // attention drive: between start max and the 165 us bound
  localparam int unsigned ATTN_CYC =
    ((MASTER_START_MAX_NS + SLAVE_ATTENTION_MAX_NS) / 2 * CLK_KHZ) / 1000000;
  localparam int unsigned RESET_CYC = (RESET_MIN_NS * CLK_KHZ + 999999) / 1000000;
  localparam longint unsigned POWERUP_CYC = longint'(POWERUP_MAX_MS) * CLK_KHZ;
  // class thresholds between adjacent ranges
  localparam int unsigned THR_ONE_CYC =
    ((MASTER_SHORT_MAX_NS + SLAVE_READ_ONE_MIN_NS) / 2 * CLK_KHZ) / 1000000;
  localparam int unsigned THR_START_CYC =
    ((MASTER_LONG_MAX_NS + MASTER_START_MIN_NS) / 2 * CLK_KHZ) / 1000000;
  localparam int unsigned THR_ATTN_CYC = (MASTER_START_MAX_NS * CLK_KHZ) / 1000000 + 1;
  localparam int unsigned THR_RESET_CYC =
    ((SLAVE_ATTENTION_MAX_NS + RESET_MIN_NS) / 2 * CLK_KHZ) / 1000000;
  // data bits after reset before attention is allowed
  localparam int unsigned ATTN_GATE_BITS = 14;
  localparam int unsigned CNT_W = 13;
  // received pulse classes
  typedef enum logic [2:0] {
    PWB_CLS_ZERO = 3'h0,
    PWB_CLS_ONE = 3'h1,
    PWB_CLS_START = 3'h2,
    PWB_CLS_ATTN = 3'h3,
    PWB_CLS_RESET = 3'h4
  } pwb_cls_e;
  // receive event carrier
  typedef struct packed {
    logic valid;
    pwb_cls_e cls;
  } pwb_evt_s;
endpackage

// ===== rtl/pwb_bit_layer.sv
// module: sensor-side bit-signal layer of the single-wire pulse-width bus
// Notes on behaviour
// [R1] attention only after line high 11 us
// [R2] master short pulse 11.8 to 17.0 us
// [R3] master long pulse 35.4 to 48.9 us
// [R4] react to falling edge within 9.6 us
// [R5] read one held low 28.3-38.3 us
// [R6] master start pulse 80 to 109 us
// [R7] attention pulse longer than start, under 165
// [R8] reset holds line low at least 354 us
// [R9] release line within 500 ms of power-up
// [R10] short pulse zero, long pulse one
// [R11] read zero leaves line undriven
// [R12] start bit always watched, aborts transaction
// [R13] no attention until 14 data bits after reset
// [R14] classify width by thresholds, longest class wins
module pwb_bit_layer
  import pwb_pkg::*;
#(
  parameter longint unsigned POWERUP_HOLD_CYC = POWERUP_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SWD_I,
  output logic SWD_O,
  output logic SWD_OE,
  input wire logic READ_BIT,
  input wire logic READ_VAL,
  input wire logic ATTN_REQ,
  input wire logic RESET_REQ,
  output logic ATTN_BUSY,
  output logic RX_VALID,
  output logic [2:0] RX_CLASS,
  output logic ABORT,
  output logic BUS_RESET
);
  typedef enum logic [1:0] {
    PWB_DRV_IDLE = 2'h0,
    PWB_DRV_LOW = 2'h1,
    PWB_DRV_WAIT = 2'h3
  } pwb_drv_e;

  logic swd_m_ff; // first synchroniser stage
  logic swd_s_ff; // synchronised line
  logic swd_d_ff; // previous synchronised level
  logic [CNT_W-1:0] low_cnt_ff; // low width counter
  logic [CNT_W-1:0] high_cnt_ff; // high width counter
  logic [CNT_W-1:0] drv_cnt_ff; // own drive counter
  logic [CNT_W-1:0] drv_len_ff; // own drive length
  logic [28:0] pwr_cnt_ff; // power-up hold counter
  logic pwr_done_ff; // power-up hold over
  pwb_drv_e drv_st_ff; // drive state
  logic [3:0] bits_ff; // data bits since reset
  logic gate_ff; // attention enabled
  logic attn_pend_ff; // attention waiting
  pwb_evt_s evt_ff; // class event out
  logic abort_ff; // abort pulse
  logic bus_rst_ff; // reset pulse
  logic fall; // falling edge on line
  logic rise; // rising edge on line
  logic idle_ok; // line high long enough
  pwb_cls_e cls; // class of ended pulse
  pwb_evt_s nxt_evt;

  // two-flop synchroniser on the line
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      swd_m_ff <= 1'b1;
      swd_s_ff <= 1'b1;
      swd_d_ff <= 1'b1;
    end else begin
      swd_m_ff <= SWD_I;
      swd_s_ff <= swd_m_ff;
      swd_d_ff <= swd_s_ff;
    end
  end

  assign fall = swd_d_ff & ~swd_s_ff;
  assign rise = ~swd_d_ff & swd_s_ff;
  assign idle_ok = swd_s_ff && (high_cnt_ff >= CNT_W'(IDLE_HIGH_CYC)); // [R1]

  // low and high width counters, saturating
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt_ff <= '0;
      high_cnt_ff <= '0;
    end else begin
      if (swd_s_ff) begin
        low_cnt_ff <= '0;
      end else if (low_cnt_ff != '1) begin
        low_cnt_ff <= low_cnt_ff + 1'b1;
      end
      if (!swd_s_ff) begin
        high_cnt_ff <= '0;
      end else if (high_cnt_ff != '1) begin
        high_cnt_ff <= high_cnt_ff + 1'b1;
      end
    end
  end

  // width classification, longest class first
  always_comb begin
    if (low_cnt_ff >= CNT_W'(THR_RESET_CYC)) begin // [R14] [R8]
      cls = PWB_CLS_RESET;
    end else if (low_cnt_ff >= CNT_W'(THR_ATTN_CYC)) begin // [R7]
      cls = PWB_CLS_ATTN;
    end else if (low_cnt_ff >= CNT_W'(THR_START_CYC)) begin // [R6] [R12]
      cls = PWB_CLS_START;
    end else if (low_cnt_ff >= CNT_W'(THR_ONE_CYC)) begin // [R3] [R10]
      cls = PWB_CLS_ONE;
    end else begin // [R2] [R10]
      cls = PWB_CLS_ZERO;
    end
    nxt_evt.valid = rise;
    nxt_evt.cls = cls;
  end

  // receive events, abort on start, reset notice
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      evt_ff <= '0;
      abort_ff <= 1'b0;
      bus_rst_ff <= 1'b0;
    end else begin
      evt_ff <= nxt_evt;
      abort_ff <= rise && (cls == PWB_CLS_START); // [R12]
      bus_rst_ff <= rise && (cls == PWB_CLS_RESET); // [R8]
    end
  end

  // data-bit count gating attention after reset
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bits_ff <= '0;
      gate_ff <= 1'b0;
    end else if (rise && cls == PWB_CLS_RESET) begin
      bits_ff <= '0;
      gate_ff <= 1'b0;
    end else if (rise && (cls == PWB_CLS_ZERO || cls == PWB_CLS_ONE) && !gate_ff) begin
      if (bits_ff == 4'(ATTN_GATE_BITS - 1)) begin // [R13]
        gate_ff <= 1'b1;
      end
      bits_ff <= bits_ff + 1'b1;
    end
  end

  // power-up hold, then release
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pwr_cnt_ff <= '0;
      pwr_done_ff <= 1'b0;
    end else if (!pwr_done_ff) begin
      pwr_cnt_ff <= pwr_cnt_ff + 1'b1;
      if (pwr_cnt_ff >= 29'(POWERUP_HOLD_CYC - 1)) begin // [R9]
        pwr_done_ff <= 1'b1;
      end
    end
  end

  // pending attention, set wins over launch clear
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      attn_pend_ff <= 1'b0;
    end else if (ATTN_REQ) begin
      attn_pend_ff <= 1'b1;
    end else if (drv_st_ff == PWB_DRV_IDLE && pwr_done_ff && !RESET_REQ
        && idle_ok && gate_ff) begin // [R7]
      // clear only when the attention drive really launches, not when reset wins
      attn_pend_ff <= 1'b0;
    end
  end

  // own drive: read one, attention, reset
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      drv_st_ff <= PWB_DRV_IDLE;
      drv_cnt_ff <= '0;
      drv_len_ff <= '0;
    end else begin
      case (drv_st_ff)
        PWB_DRV_IDLE: begin
          drv_cnt_ff <= '0;
          if (!pwr_done_ff) begin
            drv_len_ff <= '0;
          end else if (RESET_REQ && idle_ok) begin // [R8]
            drv_len_ff <= CNT_W'(RESET_CYC);
            drv_st_ff <= PWB_DRV_LOW;
          end else if (attn_pend_ff && idle_ok && gate_ff) begin // [R1] [R13]
            drv_len_ff <= CNT_W'(ATTN_CYC); // [R7]
            drv_st_ff <= PWB_DRV_LOW;
          end else if (fall && READ_BIT && READ_VAL) begin // [R4]
            drv_len_ff <= CNT_W'(READ_ONE_CYC); // [R5]
            drv_st_ff <= PWB_DRV_LOW;
          end
        end
        PWB_DRV_LOW: begin
          drv_cnt_ff <= drv_cnt_ff + 1'b1;
          if (drv_cnt_ff == drv_len_ff - 1'b1) begin
            drv_st_ff <= PWB_DRV_WAIT;
          end
        end
        PWB_DRV_WAIT: begin
          if (swd_s_ff) begin
            drv_st_ff <= PWB_DRV_IDLE;
          end
        end
        default: drv_st_ff <= PWB_DRV_IDLE;
      endcase
    end
  end

  // open-drain: drive low only; read zero leaves line free
  assign SWD_O = 1'b0;
  assign SWD_OE = !pwr_done_ff || (drv_st_ff == PWB_DRV_LOW); // [R9] [R11]
  assign ATTN_BUSY = attn_pend_ff;
  assign RX_VALID = evt_ff.valid;
  assign RX_CLASS = evt_ff.cls;
  assign ABORT = abort_ff;
  assign BUS_RESET = bus_rst_ff;

  chk_powerup_release: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R9]
    (pwr_cnt_ff >= 29'(POWERUP_HOLD_CYC)) |-> pwr_done_ff)
    else $error("line held past power-up limit");
  chk_read_one_len: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R5]
    $rose(SWD_OE) && drv_len_ff == CNT_W'(READ_ONE_CYC)
      |-> ##282 SWD_OE ##[1:101] !SWD_OE)
    else $error("read one drive length wrong");
  chk_attn_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R13]
    $rose(SWD_OE) && drv_len_ff == CNT_W'(ATTN_CYC) |-> gate_ff)
    else $error("attention before 14 data bits");
  chk_attn_idle: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R1]
    $rose(SWD_OE) && drv_len_ff == CNT_W'(ATTN_CYC)
      |-> $past(high_cnt_ff) >= CNT_W'(IDLE_HIGH_CYC))
    else $error("attention without idle");
  chk_edge_react: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R4]
    drv_st_ff == PWB_DRV_IDLE && pwr_done_ff && fall && READ_BIT && READ_VAL
      && !RESET_REQ && !(attn_pend_ff && idle_ok && gate_ff) |=> SWD_OE)
    else $error("late reaction to falling edge");
  chk_read_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R11]
    drv_st_ff == PWB_DRV_IDLE && pwr_done_ff && fall && READ_BIT && !READ_VAL
      && !RESET_REQ && !attn_pend_ff |=> !SWD_OE)
    else $error("line driven on read zero");
  chk_start_abort: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R12]
    rise && low_cnt_ff >= CNT_W'(THR_START_CYC) && low_cnt_ff < CNT_W'(THR_ATTN_CYC)
      |=> ABORT && RX_CLASS == PWB_CLS_START)
    else $error("start bit not aborting");
  chk_class_order: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // [R14]
    rise && low_cnt_ff >= CNT_W'(THR_RESET_CYC) |=> BUS_RESET && !ABORT)
    else $error("long pulse not taken as reset");
endmodule

// ===== dv/pwb_master_model.sv
// bus master model: open-drain low pulses on the shared line
module pwb_master_model (
  input wire logic clk,
  input wire logic line,
  output logic pull_low
);
  timeunit 1ns;
  timeprecision 1ns;
  int hi_run = 0; // consecutive idle cycles seen
  initial pull_low = 1'b0;
  // idle tracker, a master waits for an inactive bus for at most 20000 cycles
  always @(posedge clk) begin
    hi_run <= line ? hi_run + 1 : 0;
  end
  // one low pulse of n cycles once the line has been idle 150 cycles, or after 20000 cycles of waiting
  task automatic send(input int n);
    int k;
    k = 0;
    while (hi_run < 150 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    pull_low <= 1'b1;
    repeat (n) @(posedge clk);
    pull_low <= 1'b0;
  endtask
endmodule

// ===== dv/pwb_bit_layer_tb_top.sv
// testbench: master pulses, read replies, attention and reset drives
module pwb_bit_layer_tb_top import pwb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, swd_o, swd_oe, read_bit, read_val, attn_req, reset_req;
  logic attn_busy, rx_valid, abort, bus_reset, m_low, line;
  logic [2:0] rx_class;
  logic [2:0] exp_q[$]; // expected pulse classes, oldest first
  logic [31:0] seed;
  int n_errors = 0, cmp_count = 0, cyc = 0, oe_run = 0, oe_len = 0, hi_run = 0;
  int t_fall = 0, t_oe = 0, oe_rises = 0, hi_at_oe = 0, n_abort = 0, n_breset = 0;
  int base;
  // wired-and line with pull-up
  assign line = (swd_oe ? swd_o : 1'b1) & ~m_low;
  pwb_bit_layer #(.POWERUP_HOLD_CYC(20)) i_pwb_bit_layer (.SYS_CLK(sys_clk),
    .RST_N(rst_n), .SWD_I(line), .SWD_O(swd_o), .SWD_OE(swd_oe), .READ_BIT(read_bit),
    .READ_VAL(read_val), .ATTN_REQ(attn_req), .RESET_REQ(reset_req),
    .ATTN_BUSY(attn_busy), .RX_VALID(rx_valid), .RX_CLASS(rx_class), .ABORT(abort),
    .BUS_RESET(bus_reset));
  pwb_master_model i_pwb_master_model (.clk(sys_clk), .line(line), .pull_low(m_low));
  // clock source
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  function automatic int rnd(input int lo, input int span);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return lo + int'(seed % span);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // note expectation, then let the master send the pulse
  task automatic pulse(input logic [2:0] cls, input int n);
    exp_q.push_back(cls);
    i_pwb_master_model.send(n);
  endtask
  // bounded wait for the next sensor drive
  task automatic wait_drive(input int from);
    int k;
    for (k = 0; k < 800 && oe_rises == from; k++) @(negedge sys_clk);
  endtask
  // output watcher, sampled on settled values
  always @(negedge sys_clk) begin
    cyc++;
    if (swd_oe) oe_run++;
    else if (oe_run != 0) begin
      oe_len = oe_run;
      oe_run = 0;
    end
    if (swd_oe && oe_run == 1) begin
      oe_rises++;
      t_oe = cyc;
      hi_at_oe = hi_run;
    end
    if (!line && hi_run != 0) t_fall = cyc;
    hi_run = line ? hi_run + 1 : 0;
    if (abort) n_abort++;
    if (bus_reset) n_breset++;
    if (rx_valid) begin
      if (exp_q.size() == 0) check("rx_spurious", 0, 1);
      else check("rx_class", exp_q.pop_front(), rx_class);
    end
    if (cyc == 60000) begin
      n_errors++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    seed = 32'hCC81;
    {rst_n, read_bit, read_val, attn_req, reset_req} = 5'h00;
    // own power-up hold ends as a short low pulse
    exp_q.push_back(PWB_CLS_ZERO);
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(negedge sys_clk);
    check("oe_held", 1, swd_oe);
    repeat (25) @(negedge sys_clk);
    check("oe_hold", 0, swd_oe);
    pulse(PWB_CLS_ZERO, rnd(118, 53));
    pulse(PWB_CLS_ONE, rnd(354, 136));
    pulse(PWB_CLS_START, rnd(800, 291));
    @(posedge sys_clk);
    {read_bit, read_val} <= 2'b10;
    base = oe_rises;
    pulse(PWB_CLS_ZERO, rnd(118, 53));
    repeat (300) @(negedge sys_clk);
    check("read_zero_oe", base, oe_rises);
    @(posedge sys_clk);
    read_val <= 1'b1;
    pulse(PWB_CLS_ONE, rnd(118, 53));
    repeat (400) @(negedge sys_clk);
    check("read_one_len", 1, oe_len inside {[283:383]});
    check("edge_latency", 1, (t_oe - t_fall) <= 96);
    @(posedge sys_clk);
    {read_bit, read_val} <= 2'b00;
    pulse(PWB_CLS_RESET, rnd(3540, 100));
    repeat (20) @(posedge sys_clk);
    attn_req <= 1'b1;
    @(posedge sys_clk);
    attn_req <= 1'b0;
    @(negedge sys_clk);
    check("attn_busy_set", 1, attn_busy);
    base = oe_rises;
    for (int i = 0; i < 13; i++) begin
      if (rnd(0, 2) == 1) pulse(PWB_CLS_ONE, rnd(354, 136));
      else pulse(PWB_CLS_ZERO, rnd(118, 53));
    end
    repeat (300) @(negedge sys_clk);
    check("attn_gated", base, oe_rises);
    check("attn_waiting", 1, attn_busy);
    // fourteenth data bit ends before the attention drive starts
    pulse(PWB_CLS_ZERO, rnd(118, 53));
    exp_q.push_back(PWB_CLS_ATTN);
    wait_drive(base);
    check("attn_busy_clr", 0, attn_busy);
    repeat (1700) @(negedge sys_clk);
    check("attn_len", 1, oe_len inside {[1091:1649]});
    check("attn_idle", 1, hi_at_oe >= 110);
    base = oe_rises;
    exp_q.push_back(PWB_CLS_RESET);
    @(posedge sys_clk);
    reset_req <= 1'b1;
    wait_drive(base);
    @(posedge sys_clk);
    reset_req <= 1'b0;
    repeat (3700) @(negedge sys_clk);
    check("reset_len", 1, oe_len >= 3540);
    check("queue_left", 0, exp_q.size());
    check("aborts", 1, n_abort);
    check("bus_resets", 2, n_breset);
    complete_run();
  end
endmodule
